// ==== design/slrc_pkg.sv ====
// constants, types and reset values for the status indicator and reset controller
// Behaviour
// - strobe pin held low past 90ms: red
// - periphery fault: indicators alternate, second priority
// - address zero: green, data port refused
// - no-exchange red after soft or watchdog reset
// - no-exchange red suppressed unless watchdog activated
// - established data exchange shows green, lowest priority
// - flashing patterns toggle at about 2Hz
// - only highest priority condition is shown
// - repeater mode: green carries resynchronised Manchester copy
// - repeater mode: check telegram, remove tolerable jitter
// - repeater mode: telegram error holds output inactive
// - repeater mode: red output stays released high
// - detect 5.33MHz or 16MHz crystal, adapt clocking
// - clock watchdog resets after 20us without oscillation
// - any reset loads outputs F, drivers high impedance
// - non power-on reset pulses both strobes together
// - reset sets exchange inhibit until parameters written
// - soft or external reset initialises within 2ms
// - power-on initialises within 30ms, or 1000ms
package slrc_pkg;

    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;

    localparam int unsigned EXT_RST_MS = 90;
    localparam logic [31:0] EXT_RST_CYC = 32'(EXT_RST_MS * CLK_KHZ);
    localparam int unsigned INIT_SOFT_MS = 2;
    localparam logic [31:0] INIT_SOFT_CYC = 32'(INIT_SOFT_MS * CLK_KHZ);
    localparam int unsigned INIT_POR_MS = 30;
    localparam logic [31:0] INIT_POR_CYC = 32'(INIT_POR_MS * CLK_KHZ);
    localparam int unsigned INIT_POR_BIG_MS = 1000;
    localparam logic [31:0] INIT_POR_BIG_CYC = 32'(INIT_POR_BIG_MS * CLK_KHZ);
    localparam int unsigned CLKWDG_NS = 20000;
    localparam logic [31:0] CLKWDG_CYC = 32'(CLKWDG_NS * CLK_MHZ / 1000);
    localparam int unsigned STROBE_NS = 1000;
    localparam logic [31:0] STROBE_CYC = 32'(STROBE_NS * CLK_MHZ / 1000);

    // crystal detection: rising crystal edges counted over a fixed window
    localparam int unsigned XTAL_LOW_HZ = 5330000;
    localparam int unsigned XTAL_HIGH_HZ = 16000000;
    localparam int unsigned XTAL_WIN_NS = 1000;
    localparam logic [7:0] XTAL_WIN_CYC = 8'(XTAL_WIN_NS * CLK_MHZ / 1000);
    localparam logic [7:0] XTAL_EDGE_MIN = 8'h0A;

    // flash half period counted in crystal cycles
    localparam int unsigned FLASH_HZ = 2;
    localparam logic [31:0] FLASH_HALF_LOW = 32'(XTAL_LOW_HZ / (2 * FLASH_HZ));
    localparam logic [31:0] FLASH_HALF_HIGH = 32'(XTAL_HIGH_HZ / (2 * FLASH_HZ));

    // repeater grid: half bit, tolerated edge offsets, error hold
    localparam int unsigned HALF_BIT_NS = 3000;
    localparam logic [31:0] HALF_CYC = 32'(HALF_BIT_NS * CLK_MHZ / 1000);
    localparam logic [31:0] HALF_MID = HALF_CYC / 2;
    localparam int unsigned JIT_LATE_NS = 1500;
    localparam logic [31:0] JIT_LATE_CYC = 32'(JIT_LATE_NS * CLK_MHZ / 1000);
    localparam int unsigned JIT_EARLY_NS = 875;
    localparam logic [31:0] JIT_EARLY_CYC = 32'(JIT_EARLY_NS * CLK_MHZ / 1000);
    localparam int unsigned ERR_HOLD_US = 100;
    localparam logic [31:0] ERR_HOLD_CYC = 32'(ERR_HOLD_US * CLK_MHZ);

    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] ADDR_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam int unsigned CTRL_MASTER_BIT = 0;
    localparam int unsigned CTRL_WDG_BIT = 1;
    localparam int unsigned STAT_EXCH_DIS = 0;
    localparam int unsigned STAT_NO_EXCH = 1;
    localparam int unsigned STAT_EXT_RST = 2;
    localparam int unsigned STAT_XTAL16 = 3;
    localparam int unsigned STAT_CLK_DEAD = 4;
    localparam int unsigned STAT_RUN = 5;
    localparam int unsigned STAT_FAULT = 6;
    localparam logic [3:0] OUT_RST = 4'hF;

    typedef enum logic [1:0] {ST_INIT, ST_STROBE, ST_RUN} slrc_state_t;
    typedef enum logic [1:0] {RP_IDLE, RP_RUN, RP_HOLD} slrc_rep_t;

    typedef struct packed {
        slrc_state_t state;
        logic [31:0] cnt;
        logic por;
        logic [3:0] data;
        logic [3:0] param;
        logic exch_dis;
        logic no_exch;
        logic [31:0] ext_cnt;
        logic ext_active;
        logic xtal_prev;
        logic [7:0] xwin;
        logic [7:0] xedges;
        logic xtal16;
        logic [31:0] wdg_cnt;
        logic clk_dead;
        logic [31:0] flash_cnt;
        logic flash;
        logic master;
        logic wdg_en;
        logic [4:0] addr;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic green_n;
        logic red_n;
        logic strobe_n;
        slrc_rep_t rp_state;
        logic [31:0] rp_cnt;
        logic rp_half;
        logic rp_start;
        logic rp_first;
        logic rp_samp;
        logic rp_out;
        logic rx_prev;
    } slrc_regs_t;

    localparam slrc_regs_t REGS_RST = '{
        state: ST_INIT, rp_state: RP_IDLE, por: 1'b1, data: OUT_RST, param: OUT_RST,
        exch_dis: 1'b1, green_n: 1'b1, red_n: 1'b1, strobe_n: 1'b1, rp_out: 1'b1,
        rx_prev: 1'b1, default: '0};

endpackage

// ==== design/slrc_top.sv ====
// status indicator, reset sequencing and telegram repeater with apb registers
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module slrc_top
    import slrc_pkg::*;
#(
    parameter logic [31:0] EXT_RESET_CYCLES = EXT_RST_CYC,
    parameter logic [31:0] INIT_SOFT_CYCLES = INIT_SOFT_CYC,
    parameter logic [31:0] INIT_POR_CYCLES = INIT_POR_CYC,
    parameter logic [31:0] INIT_POR_BIG_CYCLES = INIT_POR_BIG_CYC,
    parameter logic [31:0] CLK_WDG_CYCLES = CLKWDG_CYC,
    parameter logic [31:0] FLASH_LOW_CYCLES = FLASH_HALF_LOW,
    parameter logic [31:0] FLASH_HIGH_CYCLES = FLASH_HALF_HIGH,
    parameter logic [31:0] ERR_HOLD_CYCLES = ERR_HOLD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic crystal_in,
    input wire logic periphery_fault_n_in,
    input wire logic slave_reset_call_in,
    input wire logic broadcast_reset_call_in,
    input wire logic comm_wdg_expired_in,
    input wire logic write_param_in,
    input wire logic [3:0] param_in,
    input wire logic data_exch_in,
    input wire logic [3:0] data_in,
    input wire logic large_cap_in,
    input wire logic bus_rx_in,
    output logic [3:0] data_port_out,
    output logic [3:0] data_port_oe_n_out,
    output logic [3:0] param_port_out,
    output logic [3:0] param_port_oe_n_out,
    input wire logic data_strobe_pin_n_in,
    output logic data_strobe_n_out,
    output logic data_strobe_oe_n_out,
    output logic param_strobe_n_out,
    output logic green_indicator_out,
    output logic green_indicator_oe_n_out,
    output logic red_indicator_out,
    output logic red_indicator_oe_n_out
);

    if (EXT_RESET_CYCLES == 0 || INIT_SOFT_CYCLES == 0 || INIT_POR_CYCLES == 0 ||
        INIT_POR_BIG_CYCLES == 0 || CLK_WDG_CYCLES == 0 || FLASH_LOW_CYCLES == 0 ||
        FLASH_HIGH_CYCLES == 0 || ERR_HOLD_CYCLES == 0) begin : g_bad_param
        $error("slrc_top: every cycle count must be at least one");
    end

    function automatic logic slrc_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction

    slrc_regs_t q;
    slrc_regs_t d;
    logic fault;
    logic xedge;
    logic clk_fire;
    logic ext_fire;
    logic soft_call;
    logic rst_evt;
    logic pin_low;
    logic rx_edge;
    logic rp_err;
    logic green_on;
    logic red_on;
    logic mapped;
    logic [31:0] rd;
    logic [31:0] init_len;
    logic [31:0] flash_half;

    assign fault = !periphery_fault_n_in;

    always_comb begin
        d = q;
        rd = 32'h0000_0000;
        rp_err = 1'b0;
        green_on = 1'b0;
        red_on = 1'b0;

        // crystal activity and frequency class
        xedge = crystal_in && !q.xtal_prev;
        d.xtal_prev = crystal_in;
        if (q.xwin == XTAL_WIN_CYC - 8'h01) begin
            d.xwin = 8'h00;
            d.xedges = 8'h00;
            d.xtal16 = (q.xedges + {7'h00, xedge}) >= XTAL_EDGE_MIN;
        end else begin
            d.xwin = q.xwin + 8'h01;
            d.xedges = q.xedges + {7'h00, xedge};
        end

        // watchdog saturates so a dead oscillator fires exactly once
        clk_fire = !xedge && (q.wdg_cnt == CLK_WDG_CYCLES - 32'h0000_0001);
        if (xedge) begin
            d.wdg_cnt = 32'h0000_0000;
            d.clk_dead = 1'b0;
        end else if (q.wdg_cnt != CLK_WDG_CYCLES) begin
            d.wdg_cnt = q.wdg_cnt + 32'h0000_0001;
        end
        if (clk_fire) begin
            d.clk_dead = 1'b1;
        end

        // flash timebase counts crystal cycles, so the rate tracks the crystal
        flash_half = q.xtal16 ? FLASH_HIGH_CYCLES : FLASH_LOW_CYCLES;
        if (xedge) begin
            if (q.flash_cnt >= flash_half - 32'h0000_0001) begin
                d.flash_cnt = 32'h0000_0000;
                d.flash = !q.flash;
            end else begin
                d.flash_cnt = q.flash_cnt + 32'h0000_0001;
            end
        end

        // external reset: our own strobe drives the pin low, so it is not counted
        pin_low = !data_strobe_pin_n_in;
        ext_fire = 1'b0;
        if (q.strobe_n) begin
            if (!pin_low) begin
                d.ext_cnt = 32'h0000_0000;
                d.ext_active = 1'b0;
            end else if (q.ext_cnt != EXT_RESET_CYCLES) begin
                d.ext_cnt = q.ext_cnt + 32'h0000_0001;
                ext_fire = (q.ext_cnt == EXT_RESET_CYCLES - 32'h0000_0001);
            end
        end
        if (ext_fire) begin
            d.ext_active = 1'b1;
        end

        soft_call = slave_reset_call_in || broadcast_reset_call_in ||
            (comm_wdg_expired_in && q.wdg_en);
        rst_evt = soft_call || ext_fire || clk_fire;

        init_len = q.por ? (large_cap_in ? INIT_POR_BIG_CYCLES : INIT_POR_CYCLES)
            : INIT_SOFT_CYCLES;

        case (q.state)
            ST_INIT: begin
                if (q.cnt >= init_len - 32'h0000_0001) begin
                    d.state = ST_RUN;
                    d.cnt = 32'h0000_0000;
                    d.por = 1'b0;
                end else begin
                    d.cnt = q.cnt + 32'h0000_0001;
                end
            end
            ST_STROBE: begin
                if (q.cnt == STROBE_CYC - 32'h0000_0001) begin
                    d.strobe_n = 1'b1;
                    d.state = ST_INIT;
                    d.cnt = 32'h0000_0000;
                end else begin
                    d.cnt = q.cnt + 32'h0000_0001;
                end
            end
            ST_RUN: begin
                if (write_param_in) begin
                    d.param = param_in;
                    d.exch_dis = 1'b0;
                    d.no_exch = 1'b0;
                end else if (data_exch_in && !q.exch_dis && q.addr != 5'h00 && !q.master) begin
                    // exchange before a parameter write is refused
                    d.data = data_in;
                end
            end
            default: begin
                d.state = ST_INIT;
                d.cnt = 32'h0000_0000;
            end
        endcase

        // any reset wins over the request of the same cycle
        if (rst_evt) begin
            d.state = ST_STROBE;
            d.cnt = 32'h0000_0000;
            d.strobe_n = 1'b0;
            d.data = OUT_RST;
            d.param = OUT_RST;
            d.exch_dis = 1'b1;
            d.por = 1'b0;
            d.no_exch = soft_call;
        end

        // repeater: edges are re-timed onto a half-bit grid started by the first fall
        d.rx_prev = bus_rx_in;
        rx_edge = bus_rx_in != q.rx_prev;
        case (q.rp_state)
            RP_IDLE: begin
                d.rp_out = 1'b1;
                if (q.master && q.rx_prev && !bus_rx_in) begin
                    d.rp_state = RP_RUN;
                    d.rp_cnt = 32'h0000_0000;
                    d.rp_half = 1'b0;
                    d.rp_start = 1'b1;
                end
            end
            RP_RUN: begin
                d.rp_cnt = q.rp_cnt + 32'h0000_0001;
                if (rx_edge && q.rp_cnt > JIT_LATE_CYC && q.rp_cnt < HALF_CYC - JIT_EARLY_CYC) begin
                    rp_err = 1'b1;
                end
                if (q.rp_cnt == HALF_MID) begin
                    d.rp_samp = bus_rx_in;
                    if (!q.rp_half) begin
                        d.rp_first = bus_rx_in;
                        d.rp_start = 1'b0;
                        if (q.rp_start && bus_rx_in) begin
                            rp_err = 1'b1;
                        end
                    end else if (q.rp_first == bus_rx_in) begin
                        // two equal halves: high is the pause after a telegram
                        if (bus_rx_in) begin
                            d.rp_state = RP_IDLE;
                            d.rp_out = 1'b1;
                        end else begin
                            rp_err = 1'b1;
                        end
                    end
                end
                if (q.rp_cnt == HALF_CYC - 32'h0000_0001) begin
                    d.rp_cnt = 32'h0000_0000;
                    d.rp_half = !q.rp_half;
                    d.rp_out = q.rp_samp;
                end
                if (rp_err) begin
                    d.rp_state = RP_HOLD;
                    d.rp_cnt = 32'h0000_0000;
                    d.rp_out = 1'b1;
                end
                if (!q.master) begin
                    d.rp_state = RP_IDLE;
                end
            end
            RP_HOLD: begin
                d.rp_out = 1'b1;
                if (q.rp_cnt >= ERR_HOLD_CYCLES - 32'h0000_0001) begin
                    d.rp_state = RP_IDLE;
                    d.rp_cnt = 32'h0000_0000;
                end else begin
                    d.rp_cnt = q.rp_cnt + 32'h0000_0001;
                end
            end
            default: begin
                d.rp_state = RP_IDLE;
            end
        endcase

        // indicators, first matching condition wins
        if (q.master) begin
            d.green_n = q.rp_out;
            d.red_n = 1'b1;
        end else begin
            if (q.ext_active) begin
                red_on = 1'b1;
            end else if (fault) begin
                green_on = q.flash;
                red_on = !q.flash;
            end else if (q.addr == 5'h00) begin
                green_on = 1'b1;
            end else if (q.exch_dis && q.no_exch && q.wdg_en) begin
                red_on = 1'b1;
            end else if (q.state == ST_RUN && !q.exch_dis) begin
                green_on = 1'b1;
            end
            d.green_n = !green_on;
            d.red_n = !red_on;
        end

        // apb: zero wait states, answer prepared in the setup cycle
        mapped = slrc_hit(paddr_in, CTRL_OFS) || slrc_hit(paddr_in, ADDR_OFS) ||
            slrc_hit(paddr_in, STAT_OFS);
        if (slrc_hit(paddr_in, CTRL_OFS)) begin
            rd[CTRL_MASTER_BIT] = q.master;
            rd[CTRL_WDG_BIT] = q.wdg_en;
        end
        if (slrc_hit(paddr_in, ADDR_OFS)) begin
            rd[4:0] = q.addr;
        end
        if (slrc_hit(paddr_in, STAT_OFS)) begin
            rd[STAT_EXCH_DIS] = q.exch_dis;
            rd[STAT_NO_EXCH] = q.no_exch;
            rd[STAT_EXT_RST] = q.ext_active;
            rd[STAT_XTAL16] = q.xtal16;
            rd[STAT_CLK_DEAD] = q.clk_dead;
            rd[STAT_RUN] = q.state == ST_RUN;
            rd[STAT_FAULT] = fault;
        end
        d.pready = psel_in && !penable_in;
        d.pslverr = psel_in && !penable_in && !mapped;
        if (psel_in && !penable_in) begin
            d.prdata = pwrite_in ? 32'h0000_0000 : rd;
        end
        if (psel_in && penable_in && q.pready && pwrite_in) begin
            if (slrc_hit(paddr_in, CTRL_OFS)) begin
                d.master = pwdata_in[CTRL_MASTER_BIT];
                d.wdg_en = pwdata_in[CTRL_WDG_BIT];
            end
            if (slrc_hit(paddr_in, ADDR_OFS)) begin
                d.addr = pwdata_in[4:0];
            end
        end
    end

    // clock enable low freezes every flop, including the bus answer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= REGS_RST;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign prdata_out = q.prdata;
    assign pready_out = q.pready;
    assign pslverr_out = q.pslverr;
    assign data_port_out = q.data;
    assign data_port_oe_n_out = q.data;
    assign param_port_out = q.param;
    assign param_port_oe_n_out = q.param;
    assign data_strobe_n_out = q.strobe_n;
    assign data_strobe_oe_n_out = q.strobe_n;
    assign param_strobe_n_out = q.strobe_n;
    assign green_indicator_out = q.green_n;
    assign green_indicator_oe_n_out = q.green_n;
    assign red_indicator_out = q.red_n;
    assign red_indicator_oe_n_out = q.red_n;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    reset_loads_a: assert property ((rst_evt && ce_in) |=>
        (data_port_oe_n_out == OUT_RST && param_port_oe_n_out == OUT_RST && q.exch_dis))
        else $error("outputs not released after reset");
    strobe_pair_a: assert property ((rst_evt && ce_in) |=>
        (!data_strobe_oe_n_out && !param_strobe_n_out))
        else $error("strobes not pulsed together after reset");
    por_quiet_a: assert property (q.por |-> (param_strobe_n_out && data_strobe_oe_n_out))
        else $error("strobe during power-on initialisation");
    ext_red_a: assert property ((ce_in && !q.master && q.ext_active) |=>
        (!red_indicator_oe_n_out && green_indicator_oe_n_out))
        else $error("external reset not shown red");
    fault_alt_a: assert property ((ce_in && !q.master && !q.ext_active && fault) |=>
        (green_indicator_oe_n_out != red_indicator_oe_n_out))
        else $error("fault indication not alternating");
    addr_zero_a: assert property ((ce_in && !q.master && !q.ext_active && !fault &&
        q.addr == 5'h00) |=> (!green_indicator_oe_n_out && red_indicator_oe_n_out))
        else $error("address zero not shown green");
    wdg_quiet_a: assert property ((ce_in && !q.master && !q.ext_active && !fault &&
        !q.wdg_en) |=> red_indicator_oe_n_out)
        else $error("red shown with watchdog not activated");
    exch_block_a: assert property ((ce_in && data_exch_in && !rst_evt &&
        (q.exch_dis || q.addr == 5'h00)) |=> $stable(q.data))
        else $error("data exchange accepted while inhibited");
    master_red_a: assert property ((ce_in && q.master) |=> red_indicator_oe_n_out)
        else $error("red driven in repeater mode");
    hold_idle_a: assert property ((q.rp_state == RP_HOLD) |-> q.rp_out)
        else $error("repeater output active during error hold");

    ext_reset_c: cover property (ext_fire && ce_in);
    fault_flash_c: cover property ($rose(q.flash) && fault && !q.master);
    repeat_err_c: cover property (q.rp_state == RP_RUN ##1 q.rp_state == RP_HOLD);
    normal_run_c: cover property (q.state == ST_RUN && !q.exch_dis && !green_indicator_oe_n_out);

endmodule

`default_nettype wire

// ==== tb/slrc_far_model.sv ====
// far-side model: crystal oscillator and pulled-up strobe pin
`timescale 1ns/1ps
`default_nettype none
module slrc_far_model (
    input wire logic fast_in,
    input wire logic run_in,
    input wire logic pull_low_in,
    input wire logic strobe_oe_n_in,
    output logic osc_out,
    output logic strobe_pin_n_out
);
    realtime half;
    initial osc_out = 1'b0;
    // stopping the oscillator freezes its level, as a dead crystal would
    always begin
        half = fast_in ? 31.25 : 93.81;
        #(half);
        if (run_in) osc_out = ~osc_out;
    end
    // pull-up on the pin; low while either party pulls it down
    assign strobe_pin_n_out = !(pull_low_in || !strobe_oe_n_in);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the status indicator and reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
import slrc_pkg::*;
typedef struct {string nm; int sel; logic [31:0] exp;} slrc_note_t;
logic clk_in = 1'b0, rst_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, flt_n = 1'b1;
logic srst = 1'b0, brst = 1'b0, wp = 1'b0, dx = 1'b0, fast = 1'b0, run = 1'b1, pull = 1'b0;
logic ce = 1'b1, cwd = 1'b0, lcap = 1'b0, brx = 1'b1;
logic er, gp = 1'b1, prdy, perr, dstb, dstb_oe, pstb, grn, grn_oe, red, red_oe, osc, spin;
logic [11:0] pa = 12'h000;
logic [31:0] pwd = 32'h0000_0000, rd, prd, lf = 32'h0000_0057;
logic [3:0] pin = 4'h0, din = 4'h0, dv, dport, doe, pport, poe;
int err_total = 0, comparisons = 0, lowc = 0, skew = 0, tog = 0, cyc_n = 0;
slrc_note_t notes[$];
event look;
slrc_top #(.EXT_RESET_CYCLES(32'h0000_00C8), .INIT_SOFT_CYCLES(32'h0000_0032),
    .INIT_POR_CYCLES(32'h0000_0028), .CLK_WDG_CYCLES(32'h0000_012C),
    .FLASH_LOW_CYCLES(32'h0000_0004)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .paddr_in(pa), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .crystal_in(osc), .periphery_fault_n_in(flt_n),
    .slave_reset_call_in(srst), .broadcast_reset_call_in(brst), .comm_wdg_expired_in(cwd),
    .write_param_in(wp), .param_in(pin), .data_exch_in(dx), .data_in(din),
    .large_cap_in(lcap), .bus_rx_in(brx), .data_port_out(dport), .data_port_oe_n_out(doe),
    .param_port_out(pport), .param_port_oe_n_out(poe), .data_strobe_pin_n_in(spin),
    .data_strobe_n_out(dstb), .data_strobe_oe_n_out(dstb_oe), .param_strobe_n_out(pstb),
    .green_indicator_out(grn), .green_indicator_oe_n_out(grn_oe),
    .red_indicator_out(red), .red_indicator_oe_n_out(red_oe));
slrc_far_model far (.fast_in(fast), .run_in(run), .pull_low_in(pull),
    .strobe_oe_n_in(dstb_oe), .osc_out(osc), .strobe_pin_n_out(spin));
initial forever #2 clk_in = ~clk_in;
function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function automatic logic [31:0] pick(input int s);
    case (s)
        0: return rd;
        1: return 32'(dport);
        2: return 32'(pport);
        3: return 32'(grn);
        4: return 32'(red);
        5: return 32'(grn ^ red);
        6: return 32'(tog >= 9 && tog <= 12);
        7: return 32'(doe);
        8: return 32'(lowc);
        9: return 32'(skew);
        default: return 32'(er);
    endcase
endfunction
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
        err_total++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
endtask
task e(input string nm, input int sel, input logic [31:0] exp);
    notes.push_back('{nm, sel, exp});
    ->look;
endtask
task print_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task cyc(input int n);
    repeat (n) @(posedge clk_in);
endtask
task done(input string s);
    @(posedge clk_in);
    $display("test %s finished", s);
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1; pen <= 1'b0; pa <= a; pwr <= w; pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    // no local limit: only the bench timeout may end a hung access
    do begin
        @(posedge clk_in);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
endtask
task req(input logic isd, input logic [3:0] v);
    @(posedge clk_in);
    dx <= isd; wp <= !isd; din <= v; pin <= v;
    @(posedge clk_in);
    dx <= 1'b0; wp <= 1'b0;
    @(posedge clk_in);
endtask
always @(look) while (notes.size() > 0) begin
    chk(notes[0].nm, pick(notes[0].sel), notes[0].exp);
    void'(notes.pop_front());
end
// strobe, skew and flash activity are counted here, away from the driver
always @(posedge clk_in) begin
    cyc_n++;
    lowc += int'(dstb === 1'b0);
    skew += int'(dstb !== pstb);
    tog += int'(grn !== gp);
    gp = grn;
    if (cyc_n == 20000) begin
        err_total++;
        print_verdict();
    end
end
initial begin
    #1 rst_in = 1'b1;
    cyc(12);
    rst_in <= 1'b0;
    cyc(60);
    e("data", 1, 32'h0000_000F);
    e("data_oe", 7, 32'h0000_000F);
    e("param", 2, 32'h0000_000F);
    e("strobes", 8, 32'h0000_0000);
    e("green", 3, 32'h0000_0000);
    req(1'b1, 4'h0);
    e("data", 1, 32'h0000_000F);
    done("power_on");
    lf = nx(lf);
    dv = lf[3:0] & 4'h7;
    apb(1'b1, ADDR_OFS, 32'(lf[4:0] | 5'h01));
    req(1'b1, dv);
    e("data", 1, 32'h0000_000F);
    req(1'b0, lf[7:4]);
    e("param", 2, 32'(lf[7:4]));
    req(1'b1, dv);
    e("data", 1, 32'(dv));
    e("green", 3, 32'h0000_0000);
    // a reset call seen only while the clock enable is low must be lost
    ce <= 1'b0;
    srst <= 1'b1;
    cyc(2);
    ce <= 1'b1;
    srst <= 1'b0;
    cwd <= 1'b1;
    cyc(1);
    cwd <= 1'b0;
    cyc(2);
    e("frozen", 1, 32'(dv));
    done("exchange");
    for (int w = 0; w < 2; w++) begin
        apb(1'b1, CTRL_OFS, 32'(w) << CTRL_WDG_BIT);
        @(posedge clk_in);
        srst <= (w == 0);
        brst <= (w == 1);
        @(posedge clk_in);
        srst <= 1'b0;
        brst <= 1'b0;
        cyc(2);
        e("data", 1, 32'h0000_000F);
        cyc(320);
        e("red", 4, 32'(w == 0));
        apb(1'b0, STAT_OFS, 32'h0000_0000);
        rd = rd & 32'h0000_0021;
        e("stat", 0, 32'h0000_0021);
        if (w == 1) begin
            apb(1'b1, CTRL_OFS, 32'h0000_0003);
            cyc(3);
            e("red", 4, 32'h0000_0001);
            e("green", 3, 32'h0000_0001);
            brx <= 1'b0;
            cyc(750);
            brx <= 1'b1;
            cyc(250);
            e("repeat_low", 3, 32'h0000_0000);
            cyc(800);
            e("repeat_high", 3, 32'h0000_0001);
            apb(1'b1, CTRL_OFS, 32'h0000_0002);
        end
        req(1'b0, 4'hA);
        cyc(1);
        e("red", 4, 32'h0000_0001);
        e("green", 3, 32'h0000_0000);
    end
    done("soft_reset");
    flt_n <= 1'b0;
    cyc(30);
    e("alternate", 5, 32'h0000_0001);
    tog = 0;
    cyc(2000);
    e("flash", 6, 32'h0000_0001);
    pull <= 1'b1;
    cyc(230);
    e("red", 4, 32'h0000_0000);
    e("green", 3, 32'h0000_0001);
    pull <= 1'b0;
    flt_n <= 1'b1;
    cyc(400);
    e("strobes", 8, 32'(3 * STROBE_CYC));
    e("skew", 9, 32'h0000_0000);
    done("fault_ext");
    fast <= 1'b1;
    cyc(600);
    apb(1'b0, STAT_OFS, 32'h0000_0000);
    rd = rd & 32'h0000_0008;
    e("xtal16", 0, 32'h0000_0008);
    req(1'b0, 4'h3);
    req(1'b1, dv);
    e("data", 1, 32'(dv));
    run <= 1'b0;
    cyc(400);
    e("data", 1, 32'h0000_000F);
    run <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0000_0000);
    e("rdata", 0, 32'h0000_0000);
    e("slverr", 10, 32'h0000_0001);
    done("clock");
    print_verdict();
end
endmodule
`default_nettype wire
